// file: core/dcr_pkg.sv
// Package for the DAC control register block: frame layout, addresses, defaults
package dcr_pkg;
    localparam int DCR_FRAME_W = 24;
    localparam int DCR_DATA_W = 20;
    localparam int DCR_RW_BIT = 23;
    localparam int DCR_ADDR_HI = 22;
    localparam int DCR_ADDR_LO = 20;
    localparam logic [2:0] DCR_ADDR_DAC = 3'h1;
    localparam logic [2:0] DCR_ADDR_CTRL = 3'h2;
    localparam logic [2:0] DCR_ADDR_CLRVAL = 3'h3;
    localparam logic [2:0] DCR_ADDR_SOFT = 3'h4;
    localparam int DCR_SOFT_LOAD = 0;
    localparam int DCR_SOFT_CLEAR = 1;
    localparam int DCR_SOFT_RESET = 2;
    localparam int DCR_CTL_FBR = 1;
    localparam int DCR_CTL_TRI = 2;
    localparam int DCR_CTL_GND = 3;
    localparam int DCR_CTL_FMT = 4;
    localparam logic [19:0] DCR_DAC_RST = 20'h00000;
    localparam logic [19:0] DCR_CLRVAL_RST = 20'h00000;
    localparam logic [19:0] DCR_CTRL_RST = 20'h0000e;
    localparam logic [4:0] DCR_CNT_LAST = 5'h17;

    typedef enum logic [1:0] {
        DCR_OUT_NORMAL = 2'b00,
        DCR_OUT_CLAMP = 2'b01,
        DCR_OUT_TRI = 2'b10
    } dcr_out_state_t;

    typedef struct packed {
        logic rnw;
        logic [2:0] addr;
        logic [19:0] data;
    } dcr_frame_t;
endpackage

// file: core/dcr_top.sv
// DAC control logic: serial frame receiver, registers, soft pulses, output state
module dcr_top
    import dcr_pkg::*;
#(
    parameter int DATA_W = DCR_DATA_W
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sclk,
    input wire logic sync_b,
    input wire logic sdin,
    input wire logic output_load_b,
    input wire logic clear_to_code_b,
    output logic sdo_o,
    output logic sdo_oe_b,
    output logic [DATA_W-1:0] dac_code,
    output logic [DATA_W-1:0] dac_code_offset_binary,
    output dcr_out_state_t out_state,
    output logic feedback_resistor_select,
    output logic code_format_select
);
    // Link domain: shift register on sclk, frame handed over by toggle
    logic [DCR_FRAME_W-1:0] shift_ff;
    logic [4:0] bitcnt_ff;
    logic [DCR_FRAME_W-1:0] frame_hold_ff;
    logic frame_tgl_ff;
    logic [DCR_FRAME_W-1:0] rd_shift_ff;
    logic [DCR_FRAME_W-1:0] rd_word_ff;

    wire [DCR_FRAME_W-1:0] nxt_shift = {shift_ff[DCR_FRAME_W-2:0], sdin};
    wire frame_done = (bitcnt_ff == DCR_CNT_LAST);
    // sync_b high holds the counter clear; sclk may stop between frames

    always_ff @(posedge sclk or posedge sync_b) begin
        if (sync_b) begin
            bitcnt_ff <= 5'h00;
        end else begin
            bitcnt_ff <= frame_done ? 5'h00 : bitcnt_ff + 5'h01;
        end
    end

    always_ff @(posedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            shift_ff <= '0;
            frame_hold_ff <= '0;
            frame_tgl_ff <= 1'b0;
        end else begin
            shift_ff <= nxt_shift;
            if (frame_done && !sync_b) begin
                frame_hold_ff <= nxt_shift;
                frame_tgl_ff <= ~frame_tgl_ff;
            end
        end
    end

    // Readback word is quasi-static: it settles a few clk after the read
    // frame and the sync_b gap keeps it still at the next frame's first edge.
    // A toggle handshake cannot work here since sclk stops between frames.
    always_ff @(posedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            rd_shift_ff <= '0;
        end else if (bitcnt_ff == 5'h00) begin
            rd_shift_ff <= rd_word_ff;
        end else begin
            rd_shift_ff <= {rd_shift_ff[DCR_FRAME_W-2:0], 1'b0};
        end
    end

    // SDO launched on falling edge, from flops
    always_ff @(negedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            sdo_o <= 1'b0;
        end else begin
            sdo_o <= rd_shift_ff[DCR_FRAME_W-1];
        end
    end

    // Released at once by sync_b, since sclk may stop after the frame
    always_ff @(negedge sclk or posedge sync_b) begin
        if (sync_b) begin
            sdo_oe_b <= 1'b1;
        end else begin
            sdo_oe_b <= 1'b0;
        end
    end

    // System domain: synchronisers
    logic [2:0] tgl_sync_ff;
    logic [1:0] ld_pin_sync_ff;
    logic [1:0] clr_pin_sync_ff;
    logic ld_pin_prev_ff;
    logic clr_pin_prev_ff;
    logic [DCR_FRAME_W-1:0] frame_cap_ff;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tgl_sync_ff <= 3'b000;
            ld_pin_sync_ff <= 2'b11;
            clr_pin_sync_ff <= 2'b11;
            ld_pin_prev_ff <= 1'b1;
            clr_pin_prev_ff <= 1'b1;
        end else begin
            tgl_sync_ff <= {tgl_sync_ff[1:0], frame_tgl_ff};
            ld_pin_sync_ff <= {ld_pin_sync_ff[0], output_load_b};
            clr_pin_sync_ff <= {clr_pin_sync_ff[0], clear_to_code_b};
            ld_pin_prev_ff <= ld_pin_sync_ff[1];
            clr_pin_prev_ff <= clr_pin_sync_ff[1];
        end
    end

    // Hold register is stable for many sclk periods after the toggle
    wire frame_new = tgl_sync_ff[2] ^ tgl_sync_ff[1];
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            frame_cap_ff <= '0;
        end else if (frame_new) begin
            frame_cap_ff <= frame_hold_ff;
        end
    end

    logic frame_vld_ff;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            frame_vld_ff <= 1'b0;
        end else begin
            frame_vld_ff <= frame_new;
        end
    end

    dcr_frame_t frm;
    assign frm = dcr_frame_t'(frame_cap_ff);

    wire is_write = frame_vld_ff && !frm.rnw;
    wire is_read = frame_vld_ff && frm.rnw;
    wire wr_dac = is_write && frm.addr == DCR_ADDR_DAC;
    wire wr_ctrl = is_write && frm.addr == DCR_ADDR_CTRL;
    wire wr_clrval = is_write && frm.addr == DCR_ADDR_CLRVAL;
    wire wr_soft = is_write && frm.addr == DCR_ADDR_SOFT;

    // Reserved bits 19..3 never decoded
    wire soft_load = wr_soft && frm.data[DCR_SOFT_LOAD];
    wire soft_clear = wr_soft && frm.data[DCR_SOFT_CLEAR];
    wire soft_reset = wr_soft && frm.data[DCR_SOFT_RESET];

    wire ld_pin_low = !ld_pin_sync_ff[1];
    wire clr_pin_low = !clr_pin_sync_ff[1];
    wire ld_pin_fall = ld_pin_prev_ff && ld_pin_low;
    wire clr_pin_fall = clr_pin_prev_ff && clr_pin_low;

    wire do_clear = (soft_clear || clr_pin_fall) && !ld_pin_low;
    wire do_load = (soft_load || ld_pin_fall) && !clr_pin_low && !do_clear;

    logic [DATA_W-1:0] dac_pend_ff;
    logic [DATA_W-1:0] dac_act_ff;
    logic [DATA_W-1:0] clrval_ff;
    logic [DATA_W-1:0] ctrl_ff;

    // Soft reset reuses the power-on values, so both resets agree
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dac_pend_ff <= DCR_DAC_RST;
            dac_act_ff <= DCR_DAC_RST;
            clrval_ff <= DCR_CLRVAL_RST;
            ctrl_ff <= DCR_CTRL_RST;
        end else if (soft_reset) begin
            dac_pend_ff <= DCR_DAC_RST;
            dac_act_ff <= DCR_DAC_RST;
            clrval_ff <= DCR_CLRVAL_RST;
            ctrl_ff <= DCR_CTRL_RST;
        end else begin
            if (wr_dac) begin
                dac_pend_ff <= frm.data;
            end
            if (wr_clrval) begin
                clrval_ff <= frm.data;
            end
            if (wr_ctrl) begin
                ctrl_ff <= frm.data;
            end
            if (do_clear) begin
                dac_act_ff <= clrval_ff;
            end else if (do_load) begin
                dac_act_ff <= dac_pend_ff;
            end
        end
    end

    // Active code reaches the converter; with zero code in twos complement
    // the unloaded code maps to the midscale level after release
    wire fmt_offset = ctrl_ff[DCR_CTL_FMT];
    wire [DATA_W-1:0] code_ob = fmt_offset ? dac_act_ff
        : {~dac_act_ff[DATA_W-1], dac_act_ff[DATA_W-2:0]};

    wire tri_bit = ctrl_ff[DCR_CTL_TRI];
    wire gnd_bit = ctrl_ff[DCR_CTL_GND];
    dcr_out_state_t nxt_state;
    assign nxt_state = gnd_bit ? DCR_OUT_CLAMP
        : (tri_bit ? DCR_OUT_TRI : DCR_OUT_NORMAL);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dac_code <= DCR_DAC_RST;
            dac_code_offset_binary <= DCR_DAC_RST;
            out_state <= DCR_OUT_CLAMP;
            feedback_resistor_select <= 1'b1;
            code_format_select <= 1'b0;
        end else begin
            dac_code <= dac_act_ff;
            dac_code_offset_binary <= code_ob;
            out_state <= nxt_state;
            feedback_resistor_select <= ctrl_ff[DCR_CTL_FBR];
            code_format_select <= fmt_offset;
        end
    end

    // Readback, soft pulse register answers zero
    logic [DATA_W-1:0] rd_data;
    always_comb begin
        case (frm.addr)
            DCR_ADDR_DAC: rd_data = dac_pend_ff;
            DCR_ADDR_CTRL: rd_data = ctrl_ff;
            DCR_ADDR_CLRVAL: rd_data = clrval_ff;
            default: rd_data = '0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_word_ff <= '0;
        end else if (is_read) begin
            rd_word_ff <= {frm.rnw, frm.addr, rd_data};
        end
    end
endmodule

// file: verif/dcr_monitor.sv
// Port-level assertions for the DAC control block
module dcr_monitor
    import dcr_pkg::*;
#(
    parameter int DATA_W = DCR_DATA_W
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sclk,
    input wire logic sync_b,
    input wire logic sdin,
    input wire logic output_load_b,
    input wire logic clear_to_code_b,
    input wire logic sdo_o,
    input wire logic sdo_oe_b,
    input wire logic [DATA_W-1:0] dac_code,
    input wire logic [DATA_W-1:0] dac_code_offset_binary,
    input wire dcr_out_state_t out_state,
    input wire logic feedback_resistor_select,
    input wire logic code_format_select
);
    localparam logic [DATA_W-1:0] SIGN = {1'h1, {(DATA_W-1){1'h0}}};
    default clocking dcr_cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    AST_RST_STATE: assert property ($rose(rst_b) |-> out_state == DCR_OUT_CLAMP
        && dac_code == {DATA_W{1'h0}} && feedback_resistor_select && !code_format_select)
        else $error("outputs not at power-on values");
    AST_STATE_CODE: assert property (out_state != 2'h3)
        else $error("undefined output state");
    AST_STATE_HOLD: assert property ($changed(out_state) |-> sync_b)
        else $error("output state moved inside a frame");
    AST_FBR_HOLD: assert property ($changed(feedback_resistor_select) |-> sync_b)
        else $error("resistor select moved inside a frame");
    AST_FMT_HOLD: assert property ($changed(code_format_select) |-> sync_b)
        else $error("format select moved inside a frame");
    AST_OB_MAP: assert property (($stable(dac_code) && $stable(code_format_select))[*2]
        |-> dac_code_offset_binary == (code_format_select ? dac_code : dac_code ^ SIGN))
        else $error("offset binary code does not follow format");
    AST_SDO_ENABLE: assert property ($stable(sync_b)[*3] |-> sdo_oe_b == sync_b)
        else $error("data-out enable does not follow frame select");
    AST_CLEAR_BLOCKS: assert property ((!clear_to_code_b && sync_b)[*8]
        |-> $stable(dac_code))
        else $error("active code moved while clear pin held");
    AST_LOAD_BLOCKED: assert property ($fell(output_load_b) && !clear_to_code_b
        |-> ##1 $stable(dac_code)[*6])
        else $error("load pin acted while clear pin held");
endmodule

bind dcr_top dcr_monitor #(.DATA_W(DATA_W)) dcr_monitor_i (.clk(clk), .rst_b(rst_b),
    .sclk(sclk), .sync_b(sync_b), .sdin(sdin), .output_load_b(output_load_b),
    .clear_to_code_b(clear_to_code_b), .sdo_o(sdo_o), .sdo_oe_b(sdo_oe_b),
    .dac_code(dac_code), .dac_code_offset_binary(dac_code_offset_binary),
    .out_state(out_state), .feedback_resistor_select(feedback_resistor_select),
    .code_format_select(code_format_select));

// file: verif/dcr_host.sv
// Host controller model driving the 3-wire serial link
module dcr_host (
    output logic sclk,
    output logic sync_b,
    output logic sdin,
    input wire logic sdo_o,
    input wire logic sdo_oe_b
);
    timeunit 1ns;
    timeprecision 1ps;
    wire sdo_line = sdo_oe_b ? 1'h1 : sdo_o;
    initial begin
        sclk = 1'h0;
        sync_b = 1'h1;
        sdin = 1'h0;
    end
    // One 24-bit frame, MSB first, at a 160 ns link period
    task automatic xfer(input logic [23:0] f, output logic [23:0] rd);
        sync_b = 1'h0;
        for (int i = 23; i >= 0; i--) begin
            sdin = f[i];
            #40 sclk = 1'h1;
            #80 sclk = 1'h0;
            #40 rd[i] = sdo_line;
        end
        sync_b = 1'h1;
        // Idle data line must not keep showing the last bit
        sdin = ~sdin;
        #300;
    endtask
endmodule

// file: verif/dcr_top_tb_top.sv
// Self-checking bench for the DAC control block
module dcr_top_tb_top
    import dcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [23:0] f;
        logic [43:0] e;
        logic [23:0] sdo;
    } dcr_row_t;
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    logic output_load_b = 1'h1;
    logic clear_to_code_b = 1'h1;
    logic sclk, sync_b, sdin, sdo_o, sdo_oe_b, feedback_resistor_select, code_format_select;
    logic [19:0] dac_code, dac_code_offset_binary;
    dcr_out_state_t out_state;
    logic [43:0] seen;
    logic [23:0] rd;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;
    // Expected: {code, offset code, state, resistor select, format}
    dcr_row_t rows [17] = '{
        {24'h200000, 44'h00000_80000_0, 24'h0},
        {24'h200004, 44'h00000_80000_8, 24'h0},
        {24'h20000c, 44'h00000_80000_4, 24'h0},
        {24'h200008, 44'h00000_80000_4, 24'h0},
        {24'h200012, 44'h00000_00000_3, 24'h0},
        {24'h112345, 44'h00000_00000_3, 24'h0},
        {24'h400001, 44'h12345_12345_3, 24'h0},
        {24'h3abcde, 44'h12345_12345_3, 24'h0},
        {24'h4ffff8, 44'h12345_12345_3, 24'h0},
        {24'h400002, 44'habcde_abcde_3, 24'h0},
        {24'h200002, 44'habcde_2bcde_2, 24'h0},
        {24'hb00000, 44'habcde_2bcde_2, 24'h0},
        {24'hc00000, 44'habcde_2bcde_2, 24'hbabcde},
        {24'h100001, 44'habcde_2bcde_2, 24'hc00000},
        {24'h400004, 44'h00000_80000_6, 24'h0},
        {24'hb00000, 44'h00000_80000_6, 24'h0},
        {24'hb00000, 44'h00000_80000_6, 24'hb00000}
    };
    assign seen = {dac_code, dac_code_offset_binary, out_state, feedback_resistor_select,
        code_format_select};
    always #20 clk = ~clk;
    dcr_top dcr_top_i (.clk(clk), .rst_b(rst_b), .sclk(sclk), .sync_b(sync_b), .sdin(sdin),
        .output_load_b(output_load_b), .clear_to_code_b(clear_to_code_b), .sdo_o(sdo_o),
        .sdo_oe_b(sdo_oe_b), .dac_code(dac_code), .dac_code_offset_binary(dac_code_offset_binary),
        .out_state(out_state), .feedback_resistor_select(feedback_resistor_select),
        .code_format_select(code_format_select));
    dcr_host dcr_host_i (.sclk(sclk), .sync_b(sync_b), .sdin(sdin), .sdo_o(sdo_o),
        .sdo_oe_b(sdo_oe_b));
    task automatic check(input string n, input logic [43:0] e, input logic [43:0] s);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic conclude();
        if (mismatches == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Whole run is near 2300 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            conclude();
        end
    end
    initial begin
        repeat (16) @(negedge clk);
        rst_b = 1'h1;
        repeat (4) @(negedge clk);
        check("reset", 44'h00000_80000_6, seen);
        foreach (rows[i]) begin
            dcr_host_i.xfer(rows[i].f, rd);
            repeat (8) @(negedge clk);
            check("outputs", rows[i].e, seen);
            if (rows[i].sdo != 24'h0) check("readback", {20'h0, rows[i].sdo}, {20'h0, rd});
        end
        dcr_host_i.xfer(24'h112345, rd);
        @(negedge clk);
        clear_to_code_b = 1'h0;
        dcr_host_i.xfer(24'h400001, rd);
        @(negedge clk);
        output_load_b = 1'h0;
        repeat (8) @(negedge clk);
        check("load_under_clear", 44'h00000_80000_6, seen);
        clear_to_code_b = 1'h1;
        output_load_b = 1'h1;
        repeat (4) @(negedge clk);
        output_load_b = 1'h0;
        dcr_host_i.xfer(24'h400002, rd);
        repeat (8) @(negedge clk);
        check("pin_load", 44'h12345_92345_6, seen);
        output_load_b = 1'h1;
        repeat (4) @(negedge clk);
        clear_to_code_b = 1'h0;
        repeat (8) @(negedge clk);
        check("pin_clear", 44'h00000_80000_6, seen);
        clear_to_code_b = 1'h1;
        conclude();
    end
endmodule
